// file: design/aspd_serial_port.sv
/*
 * Asynchronous serial transmitter/receiver with DMA link requests.
 * Assumes byte I/O strobes of one cycle, synchronous to sys_clk_i,
 * and a serial clock source no faster than a quarter of sys_clk_i.
 */
`timescale 1ns/1ps
`include "aspd_regs.svh"

module aspd_serial_port (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic timer_clk_pin_i,
    input wire logic timer_pulse_i,
    input wire logic rx_pin_i,
    output logic [7:0] io_rdata_o,
    output logic tx_pin_o,
    output logic tx_irq_o,
    output logic rx_irq_o,
    output logic rx_dma_req_o,
    output logic tx_dma_req_o
);

    // Reset release through two flops
    logic rst_s1_reg;
    logic rst_n_reg;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg <= rst_s1_reg;
        end
    end

    aspd_pkg::aspd_io_req_t req;
    assign req = '{wr: io_wr_i, rd: io_rd_i, addr: io_addr_i, wdata: io_wdata_i};

    logic [7:0] cfg_reg;
    logic [7:0] txcs_reg;
    logic [7:0] rxcs_reg;
    logic [7:0] rxd_reg;
    logic [7:0] txd_reg;
    logic [1:0] link_reg;

    // Register decode
    wire wr_cfg = req.wr && req.addr == `ASPD_OFF_CFG;
    wire wr_txcs = req.wr && req.addr == `ASPD_OFF_TXCS;
    wire wr_rxcs = req.wr && req.addr == `ASPD_OFF_RXCS;
    wire wr_txd = req.wr && req.addr == `ASPD_OFF_TXD;
    wire wr_link = req.wr && req.addr == `ASPD_OFF_LINK;
    wire rd_rxd = req.rd && req.addr == `ASPD_OFF_RXD;

    wire loop_sel = cfg_reg[`ASPD_CFG_LB];
    wire [1:0] cpb_field = cfg_reg[`ASPD_CFG_CR_LO +: 2];
    wire clk_sel = cfg_reg[`ASPD_CFG_CS];
    wire par_en = cfg_reg[`ASPD_CFG_P];
    wire par_even = cfg_reg[`ASPD_CFG_EO];
    wire [1:0] bc_field = cfg_reg[`ASPD_CFG_BC_LO +: 2];
    wire tx_en = txcs_reg[`ASPD_TX_EN];
    wire rx_en = rxcs_reg[`ASPD_RX_EN];
    wire [3:0] nbits = {2'b00, bc_field} + 4'h5;

    // Serial clock source; sampled as a level, edges found on sys_clk
    wire ser_clk_now = clk_sel ? timer_pulse_i : timer_clk_pin_i;
    logic ser_clk_reg;
    always_ff @(posedge sys_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ser_clk_reg <= 1'b0;
        end else begin
            ser_clk_reg <= ser_clk_now;
        end
    end
    wire ser_rise = ser_clk_now && !ser_clk_reg;
    wire ser_fall = !ser_clk_now && ser_clk_reg;

    // Prescale length, shared by both directions
    function automatic logic [6:0] cpb_len(input logic [1:0] f);
        unique case (f)
            2'b00: cpb_len = 7'h01;
            2'b01: cpb_len = 7'h10;
            2'b10: cpb_len = 7'h20;
            2'b11: cpb_len = 7'h40;
        endcase
    endfunction
    wire [6:0] bit_len = cpb_len(cpb_field);
    wire [6:0] half_len = (bit_len == 7'h01) ? 7'h01 : {1'b0, bit_len[6:1]};

    // Transmitter
    aspd_pkg::aspd_tx_state_t tx_state_reg;
    logic [6:0] tx_cnt_reg;
    logic [3:0] tx_idx_reg;
    logic [7:0] tx_sh_reg;
    logic tx_par_reg;
    logic tx_force_reg;
    logic tx_line_reg;
    logic tx_stop2_reg;
    wire tx_tick = ser_fall && (tx_cnt_reg == 7'h01);
    wire tx_load = tx_state_reg == aspd_pkg::ASPD_TX_IDLE && tx_en && !txcs_reg[`ASPD_TX_BE];
    // Short characters keep only their low bits
    wire [7:0] tx_mask = 8'hFF >> (4'h8 - nbits);

    always_ff @(posedge sys_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            tx_state_reg <= aspd_pkg::ASPD_TX_IDLE;
            tx_cnt_reg <= 7'h01;
            tx_idx_reg <= 4'h0;
            tx_sh_reg <= 8'h00;
            tx_par_reg <= 1'b0;
            tx_force_reg <= 1'b0;
            tx_line_reg <= 1'b1;
            tx_stop2_reg <= 1'b0;
        end else if (tx_load) begin
            tx_state_reg <= aspd_pkg::ASPD_TX_START;
            tx_cnt_reg <= bit_len;
            tx_sh_reg <= txd_reg & tx_mask;
            tx_par_reg <= ^(txd_reg & tx_mask) ^ ~par_even;
            tx_force_reg <= txcs_reg[`ASPD_TX_FRC];
            tx_stop2_reg <= 1'b0;
            tx_idx_reg <= 4'h0;
        end else if (ser_fall) begin
            tx_cnt_reg <= (tx_cnt_reg == 7'h01) ? bit_len : tx_cnt_reg - 7'h01;
            if (tx_tick) begin
                unique case (tx_state_reg)
                    aspd_pkg::ASPD_TX_IDLE: tx_line_reg <= 1'b1;
                    aspd_pkg::ASPD_TX_START: begin
                        tx_line_reg <= tx_force_reg ? txcs_reg[`ASPD_TX_VAL] : 1'b0;
                        tx_state_reg <= aspd_pkg::ASPD_TX_DATA;
                    end
                    aspd_pkg::ASPD_TX_DATA: begin
                        tx_line_reg <= tx_force_reg ? txcs_reg[`ASPD_TX_VAL] : tx_sh_reg[0];
                        tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
                        tx_idx_reg <= tx_idx_reg + 4'h1;
                        if (tx_idx_reg == nbits - 4'h1) begin
                            tx_state_reg <= par_en ? aspd_pkg::ASPD_TX_PAR
                                                   : aspd_pkg::ASPD_TX_STOP;
                        end
                    end
                    aspd_pkg::ASPD_TX_PAR: begin
                        tx_line_reg <= tx_force_reg ? txcs_reg[`ASPD_TX_VAL] : tx_par_reg;
                        tx_state_reg <= aspd_pkg::ASPD_TX_STOP;
                    end
                    aspd_pkg::ASPD_TX_STOP: begin
                        tx_line_reg <= tx_force_reg ? txcs_reg[`ASPD_TX_VAL] : 1'b1;
                        tx_stop2_reg <= 1'b1;
                        if (tx_stop2_reg || !txcs_reg[`ASPD_TX_SB]) begin
                            tx_state_reg <= aspd_pkg::ASPD_TX_IDLE;
                        end
                    end
                    default: tx_state_reg <= aspd_pkg::ASPD_TX_IDLE;
                endcase
            end
        end
    end

    // Break overrides everything; disabled and idle both mark
    wire tx_stream = txcs_reg[`ASPD_TX_BRK] ? 1'b0 : tx_line_reg;

    // Receiver input; loopback replaces the pin
    wire rx_in = loop_sel ? tx_stream : rx_pin_i;
    aspd_pkg::aspd_rx_state_t rx_state_reg;
    logic [6:0] rx_cnt_reg;
    logic [3:0] rx_idx_reg;
    logic [8:0] rx_sh_reg;
    logic rx_prev_reg;
    // In x1 mode each rising edge is a mid-bit sample point
    wire rx_step = ser_rise && (rx_cnt_reg == 7'h01);
    wire [3:0] rx_total = nbits + {3'b000, par_en};
    wire rx_done = rx_step && rx_state_reg == aspd_pkg::ASPD_RX_STOP;

    // Assembled byte: data, parity above, ones filling
    logic [7:0] rx_byte;
    logic [8:0] rx_fill;
    // Only the newest rx_total bits belong to this character; older ones drop out
    wire [8:0] rx_bits = rx_sh_reg >> (4'h9 - rx_total);
    assign rx_fill = rx_bits | (9'h1FF << rx_total);
    assign rx_byte = rx_fill[7:0];
    // Parity over received bits only, so an odd count of fill ones cannot skew it
    wire rx_par_bad = par_en && (^rx_bits ^ ~par_even);
    wire rx_frm_bad = !rx_in;

    always_ff @(posedge sys_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rx_state_reg <= aspd_pkg::ASPD_RX_IDLE;
            rx_cnt_reg <= 7'h01;
            rx_idx_reg <= 4'h0;
            rx_sh_reg <= 9'h000;
            rx_prev_reg <= 1'b1;
        end else if (!rx_en) begin
            rx_state_reg <= aspd_pkg::ASPD_RX_IDLE;
            rx_prev_reg <= 1'b1;
        end else if (ser_rise) begin
            rx_prev_reg <= rx_in;
            rx_cnt_reg <= (rx_cnt_reg == 7'h01) ? bit_len : rx_cnt_reg - 7'h01;
            unique case (rx_state_reg)
                aspd_pkg::ASPD_RX_IDLE: begin
                    // In x1 the detecting edge is already mid start bit; no half-bit wait
                    if (rx_prev_reg && !rx_in) begin
                        rx_state_reg <= (bit_len == 7'h01) ? aspd_pkg::ASPD_RX_DATA
                                                           : aspd_pkg::ASPD_RX_START;
                        rx_idx_reg <= 4'h0;
                        rx_cnt_reg <= half_len;
                    end
                end
                aspd_pkg::ASPD_RX_START: begin
                    if (rx_step) begin
                        rx_state_reg <= rx_in ? aspd_pkg::ASPD_RX_IDLE
                                              : aspd_pkg::ASPD_RX_DATA;
                        rx_idx_reg <= 4'h0;
                    end
                end
                aspd_pkg::ASPD_RX_DATA: begin
                    if (rx_step) begin
                        rx_sh_reg <= {rx_in, rx_sh_reg[8:1]};
                        rx_idx_reg <= rx_idx_reg + 4'h1;
                        if (rx_idx_reg == rx_total - 4'h1) begin
                            rx_state_reg <= aspd_pkg::ASPD_RX_STOP;
                        end
                    end
                end
                aspd_pkg::ASPD_RX_STOP: begin
                    if (rx_step) begin
                        rx_state_reg <= rx_frm_bad ? aspd_pkg::ASPD_RX_HOLD
                                                   : aspd_pkg::ASPD_RX_IDLE;
                        rx_cnt_reg <= half_len;
                    end
                end
                aspd_pkg::ASPD_RX_HOLD: begin
                    if (rx_step) begin
                        rx_state_reg <= aspd_pkg::ASPD_RX_IDLE;
                    end
                end
                default: rx_state_reg <= aspd_pkg::ASPD_RX_IDLE;
            endcase
        end
    end

    // Receive status; a load in the same cycle as a read wins
    logic [7:0] rxcs_next;
    always_comb begin
        rxcs_next = rxcs_reg;
        if (wr_rxcs) begin
            rxcs_next[`ASPD_RX_EN] = req.wdata[`ASPD_RX_EN];
            rxcs_next[`ASPD_RX_IE] = req.wdata[`ASPD_RX_IE];
            rxcs_next[`ASPD_RX_PE] = req.wdata[`ASPD_RX_PE] & rxcs_reg[`ASPD_RX_PE];
            rxcs_next[`ASPD_RX_OVE] = req.wdata[`ASPD_RX_OVE] & rxcs_reg[`ASPD_RX_OVE];
        end
        if (rd_rxd) begin
            rxcs_next[`ASPD_RX_CA] = 1'b0;
        end
        if (rx_done) begin
            rxcs_next[`ASPD_RX_CA] = 1'b1;
            rxcs_next[`ASPD_RX_FE] = rx_frm_bad;
            if (rx_par_bad) begin
                rxcs_next[`ASPD_RX_PE] = 1'b1;
            end
            if (rxcs_reg[`ASPD_RX_CA] && !rd_rxd) begin
                rxcs_next[`ASPD_RX_OVE] = 1'b1;
            end
        end
        rxcs_next[5] = 1'b0;
        rxcs_next[`ASPD_RX_ERR] = rxcs_next[`ASPD_RX_PE] | rxcs_next[`ASPD_RX_OVE]
                                  | rxcs_next[`ASPD_RX_FE];
    end

    // Transmit status; buffer empty set by the load into the shifter
    logic [7:0] txcs_next;
    always_comb begin
        txcs_next = txcs_reg;
        if (wr_txcs) begin
            txcs_next[6:0] = {req.wdata[6], 1'b0, req.wdata[4:0]};
        end
        if (tx_load) begin
            txcs_next[`ASPD_TX_BE] = 1'b1;
        end else if (wr_txd) begin
            txcs_next[`ASPD_TX_BE] = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            cfg_reg <= `ASPD_CFG_RESET;
            txcs_reg <= `ASPD_TXCS_RESET | (8'h01 << `ASPD_TX_BE);
            rxcs_reg <= `ASPD_RXCS_RESET;
            rxd_reg <= 8'h00;
            txd_reg <= 8'h00;
            link_reg <= 2'b00;
        end else begin
            if (wr_cfg) begin
                cfg_reg <= req.wdata;
            end
            if (wr_link) begin
                link_reg <= req.wdata[`ASPD_LINK_TX:`ASPD_LINK_RX];
            end
            if (wr_txd) begin
                txd_reg <= req.wdata;
            end
            if (rx_done) begin
                rxd_reg <= rx_byte;
            end
            txcs_reg <= txcs_next;
            rxcs_reg <= rxcs_next;
        end
    end

    // Read mux and registered outputs
    wire [7:0] rd_mux = (req.addr == `ASPD_OFF_CFG) ? cfg_reg :
                        (req.addr == `ASPD_OFF_TXCS) ? txcs_reg :
                        (req.addr == `ASPD_OFF_RXCS) ? rxcs_reg :
                        (req.addr == `ASPD_OFF_RXD) ? rxd_reg :
                        (req.addr == `ASPD_OFF_LINK) ? {6'h00, link_reg} : 8'h00;
    aspd_pkg::aspd_dma_req_t dreq;
    // Requests level-driven by data state; DMA side ignores unused address fields
    assign dreq = '{rx_dreq: link_reg[`ASPD_LINK_RX] & rxcs_reg[`ASPD_RX_CA],
                    tx_dreq: link_reg[`ASPD_LINK_TX] & txcs_reg[`ASPD_TX_BE]};

    always_ff @(posedge sys_clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            io_rdata_o <= 8'h00;
            tx_pin_o <= 1'b1;
            tx_irq_o <= 1'b0;
            rx_irq_o <= 1'b0;
            rx_dma_req_o <= 1'b0;
            tx_dma_req_o <= 1'b0;
        end else begin
            io_rdata_o <= req.rd ? rd_mux : 8'h00;
            tx_pin_o <= tx_stream;
            tx_irq_o <= txcs_reg[`ASPD_TX_IE] & txcs_reg[`ASPD_TX_BE];
            rx_irq_o <= rxcs_reg[`ASPD_RX_IE] & (rxcs_reg[`ASPD_RX_CA]
                                                 | rxcs_reg[`ASPD_RX_ERR]);
            rx_dma_req_o <= dreq.rx_dreq;
            tx_dma_req_o <= dreq.tx_dreq;
        end
    end

endmodule

// file: design/aspd_regs.svh
/*
 * Register offsets, field positions and reset values
 * for the serial port block. Assumes byte I/O with 8-bit data.
 */
`ifndef ASPD_REGS_SVH
`define ASPD_REGS_SVH

`define ASPD_OFF_CFG 8'h10
`define ASPD_OFF_TXCS 8'h12
`define ASPD_OFF_RXCS 8'h14
`define ASPD_OFF_RXD 8'h16
`define ASPD_OFF_TXD 8'h18
`define ASPD_OFF_LINK 8'h1F

`define ASPD_CFG_RESET 8'h00
`define ASPD_TXCS_RESET 8'h01
`define ASPD_RXCS_RESET 8'h00

`define ASPD_CFG_LB 7
`define ASPD_CFG_CR_LO 5
`define ASPD_CFG_CS 4
`define ASPD_CFG_P 3
`define ASPD_CFG_EO 2
`define ASPD_CFG_BC_LO 0

`define ASPD_TX_BE 7
`define ASPD_TX_VAL 6
`define ASPD_TX_FRC 4
`define ASPD_TX_BRK 3
`define ASPD_TX_SB 2
`define ASPD_TX_IE 1
`define ASPD_TX_EN 0

`define ASPD_RX_ERR 7
`define ASPD_RX_FE 6
`define ASPD_RX_PE 4
`define ASPD_RX_OVE 3
`define ASPD_RX_CA 2
`define ASPD_RX_IE 1
`define ASPD_RX_EN 0

`define ASPD_LINK_RX 0
`define ASPD_LINK_TX 1

`define ASPD_TXD_DAD_CODE 3'h6

`endif

// file: design/aspd_pkg.sv
/*
 * Types for the serial port block.
 * Assumes aspd_regs.svh holds the numeric constants.
 */
package aspd_pkg;

    typedef enum logic [2:0] {
        ASPD_TX_IDLE = 3'h0,
        ASPD_TX_START = 3'h1,
        ASPD_TX_DATA = 3'h3,
        ASPD_TX_PAR = 3'h2,
        ASPD_TX_STOP = 3'h6
    } aspd_tx_state_t;

    typedef enum logic [2:0] {
        ASPD_RX_IDLE = 3'h0,
        ASPD_RX_START = 3'h1,
        ASPD_RX_DATA = 3'h3,
        ASPD_RX_STOP = 3'h2,
        ASPD_RX_HOLD = 3'h6
    } aspd_rx_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } aspd_io_req_t;

    typedef struct packed {
        logic rx_dreq;
        logic tx_dreq;
    } aspd_dma_req_t;

endpackage

// file: test/aspd_serial_port_props.sv
/*
 * Port checker for the serial port block.
 * Assumes it is bound to aspd_serial_port and sees only its ports.
 */
`timescale 1ns/1ps
module aspd_serial_port_props (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_addr_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic timer_clk_pin_i,
    input wire logic timer_pulse_i,
    input wire logic rx_pin_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic tx_pin_o,
    input wire logic tx_irq_o,
    input wire logic rx_irq_o,
    input wire logic rx_dma_req_o,
    input wire logic tx_dma_req_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic cs_reg, sclk_reg;
    logic [7:0] fall_reg, txw_reg;
    logic [2:0] brk_reg;
    // Decoded accesses and the serial clock the port should be using
    wire txcs_wr = io_wr_i && io_addr_i == 8'h12;
    wire rxcs_wr = io_wr_i && io_addr_i == 8'h14;
    wire link_wr = io_wr_i && io_addr_i == 8'h1F;
    wire rxd_rd = io_rd_i && io_addr_i == 8'h16;
    wire sclk = cs_reg ? timer_pulse_i : timer_clk_pin_i;
    // Recent serial falls and control writes; the pin may move only just after one
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_reg <= 1'b0;
            sclk_reg <= 1'b0;
            fall_reg <= 8'h00;
            txw_reg <= 8'h00;
            brk_reg <= 3'h0;
        end else begin
            if (io_wr_i && io_addr_i == 8'h10) cs_reg <= io_wdata_i[4];
            sclk_reg <= sclk;
            fall_reg <= {fall_reg[6:0], sclk_reg & ~sclk};
            txw_reg <= {txw_reg[6:0], txcs_wr};
            if (txcs_wr) brk_reg <= {2'h0, io_wdata_i[3]};
            else if (brk_reg != 3'h0 && brk_reg != 3'h7) brk_reg <= brk_reg + 3'h1;
        end
    end
    brk_low_a: assert property (txcs_wr && io_wdata_i[3] |-> ##[1:3] !tx_pin_o)
        else $error("break did not pull the line low");
    brk_hold_a: assert property (brk_reg >= 3'h4 |-> !tx_pin_o)
        else $error("line high during break");
    tx_edge_a: assert property (
        $changed(tx_pin_o) |-> fall_reg != 8'h00 || txw_reg != 8'h00)
        else $error("tx pin moved away from a serial clock fall");
    link_off_a: assert property (
        link_wr && io_wdata_i[1:0] == 2'h0 |-> ##[1:3] !rx_dma_req_o && !tx_dma_req_o)
        else $error("dma request after link cleared");
    rxd_clear_a: assert property (rxd_rd |-> ##[2:3] !rx_dma_req_o)
        else $error("character still flagged after data read");
    tx_irq_off_a: assert property (txcs_wr && !io_wdata_i[1] |-> ##[1:3] !tx_irq_o)
        else $error("tx irq while disabled");
    rx_irq_off_a: assert property (rxcs_wr && !io_wdata_i[1] |-> ##[1:3] !rx_irq_o)
        else $error("rx irq while disabled");
    err_or_a: assert property (io_rd_i && io_addr_i == 8'h14 |=>
        io_rdata_o[7] == |{io_rdata_o[6], io_rdata_o[4:3]})
        else $error("summary error bit differs from its flags");
    read_idle_a: assert property (!io_rd_i |=> io_rdata_o == 8'h00)
        else $error("read data outside a read");
endmodule

bind aspd_serial_port aspd_serial_port_props props (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i),
    .timer_clk_pin_i(timer_clk_pin_i), .timer_pulse_i(timer_pulse_i), .rx_pin_i(rx_pin_i),
    .io_rdata_o(io_rdata_o), .tx_pin_o(tx_pin_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o),
    .rx_dma_req_o(rx_dma_req_o), .tx_dma_req_o(tx_dma_req_o));

// file: test/aspd_remote_station.sv
/*
 * Remote serial station: sends frames to the receive pin, grabs frames from the tx pin.
 * Assumes ser_clk_i is the serial clock that the port has selected.
 */
`timescale 1ns/1ps
module aspd_remote_station (
    input wire logic ser_clk_i,
    input wire logic line_i,
    output logic line_o
);
    int rate = 16;
    // Idle line marks high
    initial line_o = 1'b1;
    // Bits move on serial falls so that an x1 receiver samples settled data on rises
    task automatic send(input logic [11:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge ser_clk_i);
            line_o = f[i];
            repeat (rate - 1) @(negedge ser_clk_i);
        end
        @(negedge ser_clk_i);
        line_o = 1'b1;
    endtask
    // Mid-bit sampling after the start edge; unsent positions read as ones
    task automatic grab(input int n, output logic [11:0] f);
        f = '1;
        @(negedge line_i);
        repeat (rate > 1 ? rate / 2 : 1) @(posedge ser_clk_i);
        for (int i = 0; i < n; i++) begin
            f[i] = line_i;
            repeat (rate) @(posedge ser_clk_i);
        end
    endtask
endmodule

// file: test/aspd_serial_port_bench.sv
/*
 * Bench for the serial port block: byte register tasks and a remote station on the pins.
 * Assumes the block, its checker and the remote station are compiled first.
 */
`timescale 1ns/1ps
module aspd_serial_port_bench;
    logic sys_clk = 1'b0, rst_n = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
    logic [7:0] io_addr = 8'h00, io_wdata = 8'h00;
    logic pin_clk = 1'b0, pulse_clk = 1'b0, cs = 1'b0;
    logic [11:0] got, exp, rdata;
    logic [7:0] regs [5] = '{8'h10, 8'h12, 8'h14, 8'h1F, 8'h11};
    logic [11:0] rst_v [5] = '{12'h000, 12'h081, 12'h000, 12'h000, 12'h000};
    int fail_count = 0, total_checks = 0, nb = 8, pe = 0, ev = 0, sb = 0, flen = 10;
    wire [7:0] io_rdata;
    wire tx_pin, tx_irq, rx_irq, rx_dreq, tx_dreq, rx_line;
    wire sclk = cs ? pulse_clk : pin_clk;
    always #5 sys_clk = ~sys_clk;
    // Timer pin and pulse run free, unrelated to the system clock and each other
    initial #3 forever #80 pin_clk = ~pin_clk;
    initial #7 forever #120 pulse_clk = ~pulse_clk;
    aspd_serial_port uut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .io_wr_i(io_wr),
        .io_rd_i(io_rd), .io_addr_i(io_addr), .io_wdata_i(io_wdata),
        .timer_clk_pin_i(pin_clk), .timer_pulse_i(pulse_clk), .rx_pin_i(rx_line),
        .io_rdata_o(io_rdata), .tx_pin_o(tx_pin), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq),
        .rx_dma_req_o(rx_dreq), .tx_dma_req_o(tx_dreq));
    aspd_remote_station peer (.ser_clk_i(sclk), .line_i(tx_pin), .line_o(rx_line));
    task automatic chk(input logic [11:0] seen, input logic [11:0] want, input string what);
        total_checks++;
        if (seen !== want) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // One-cycle strobes; read data is taken in the cycle after the read edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1 io_wr = 1'b1;
        io_addr = a;
        io_wdata = d;
        @(posedge sys_clk);
        #1 io_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        #1 io_rd = 1'b1;
        io_addr = a;
        @(posedge sys_clk);
        #1 io_rd = 1'b0;
        rdata = {4'h0, io_rdata};
    endtask
    // Line frame, LSB first; bad[0] flips parity, bad[1] drops the stop bit
    function automatic logic [11:0] frame(input logic [7:0] d, input logic [1:0] bad);
        logic [11:0] f;
        int k;
        f = '1;
        f[0] = 1'b0;
        for (int i = 0; i < nb; i++) f[1 + i] = d[i];
        k = 1 + nb;
        if (pe != 0) begin
            f[k] = ^(d & (8'hFF >> (8 - nb))) ^ (ev == 0) ^ bad[0];
            k++;
        end
        f[k] = ~bad[1];
        flen = k + 1 + sb;
        return f;
    endfunction
    task automatic tx_chk(input logic [7:0] d);
        exp = frame(d, 2'h0);
        fork
            peer.grab(flen, got);
            wr(8'h18, d);
        join
        chk(got, exp, "tx frame");
    endtask
    // Polls the status until the chosen flag shows, bounded
    task automatic rx_send(input logic [7:0] d, input logic [1:0] bad, input int flag);
        exp = frame(d, bad);
        peer.send(exp, flen);
        for (int i = 0; i < 40; i++) begin
            rd(8'h14);
            if (rdata[flag] === 1'b1) break;
        end
    endtask
    // Tests need about 50k cycles, so this limit only trips on a hang
    initial begin
        repeat (80000) @(posedge sys_clk);
        fail_count++;
        test_done;
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge sys_clk);
        foreach (regs[i]) begin
            rd(regs[i]);
            chk(rdata, rst_v[i], "reset value");
        end
        // Every clocks-per-bit code, eight bits with even parity, looped into the receiver
        pe = 1;
        ev = 1;
        wr(8'h14, 8'h01);
        for (int r = 0; r < 4; r++) begin
            wr(8'h10, 8'h8F | 8'(r << 5));
            peer.rate = (r == 0) ? 1 : 8 << r;
            tx_chk(8'hA5 ^ 8'(r));
            rd(8'h16);
            chk(rdata, {4'h0, 8'hA5 ^ 8'(r)}, "looped byte");
        end
        // Five bits, odd parity, two stops; upper written bits must not show
        nb = 5;
        ev = 0;
        sb = 1;
        peer.rate = 16;
        wr(8'h10, 8'h28);
        wr(8'h12, 8'h05);
        tx_chk(8'hF5);
        wr(8'h1F, 8'h03);
        wr(8'h12, 8'h07);
        repeat (3) @(posedge sys_clk);
        chk({11'h0, tx_irq}, 12'h001, "tx irq");
        chk({11'h0, tx_dreq}, 12'h001, "tx dma request");
        // Short character comes back with parity above and ones filling
        wr(8'h14, 8'h03);
        rx_send(8'h15, 2'h0, 2);
        chk({11'h0, rx_irq}, 12'h001, "rx irq");
        chk({11'h0, rx_dreq}, 12'h001, "rx dma request");
        rd(8'h16);
        chk(rdata, {4'h0, exp[8:1]}, "rx byte");
        rd(8'h14);
        chk(rdata, 12'h003, "status after read");
        rx_send(8'h0A, 2'h1, 2);
        chk(rdata, 12'h097, "parity error");
        rd(8'h16);
        wr(8'h14, 8'h01);
        rx_send(8'h11, 2'h2, 2);
        chk(rdata, 12'h0C5, "framing error");
        rd(8'h16);
        rx_send(8'h06, 2'h0, 2);
        chk(rdata, 12'h005, "flags renewed");
        rx_send(8'h19, 2'h0, 3);
        chk(rdata, 12'h08D, "overrun");
        rd(8'h16);
        chk(rdata, {4'h0, exp[8:1]}, "newest byte");
        wr(8'h14, 8'h01);
        // A low shorter than half a bit must not start a character
        peer.line_o = 1'b0;
        repeat (4) @(negedge sclk);
        peer.line_o = 1'b1;
        repeat (3000) @(posedge sys_clk);
        rd(8'h14);
        chk(rdata, 12'h001, "glitch ignored");
        // Loopback on the timer pulse clock while the receive pin sits low
        nb = 8;
        pe = 0;
        cs = 1'b1;
        wr(8'h10, 8'hB3);
        peer.line_o = 1'b0;
        tx_chk(8'h3C);
        rd(8'h14);
        chk(rdata, 12'h005, "loopback status");
        rd(8'h16);
        chk(rdata, 12'h03C, "loopback byte");
        wr(8'h12, 8'h09);
        repeat (40) @(posedge sys_clk);
        chk({11'h0, tx_pin}, 12'h000, "break level");
        wr(8'h12, 8'h01);
        repeat (40) @(posedge sys_clk);
        chk({11'h0, tx_pin}, 12'h001, "idle level");
        // Forced space: every bit time of the written character goes out low
        wr(8'h12, 8'h11);
        fork
            peer.grab(10, got);
            wr(8'h18, 8'hFF);
        join
        chk(got, 12'hC00, "forced space");
        wr(8'h1F, 8'h00);
        test_done;
    end
endmodule
